// [qstf_top.sv]
// Contract
// - Rising mask bit one: a 0-to-1 condition change sets the event bit.
// - Both mask bits one: any condition change sets the event bit.
// - Both mask bits zero: no condition change sets the event bit.
// - Preset loads rising mask with all implemented bits, value 8191.
// - Mask reads return set bits, bits 13 to 15 read zero.
// - Mask filters between condition and event, one copy per channel.
// - Bits 0,1,2: over-voltage, over-current, power-fail shutdown.
// - Bit 3 positive power limit, bit 5 negative power limit.
// - Bit 4 over-temperature, bit 6 negative over-voltage, bit 12 oscillation.
// - Bit 7 positive V/I limit, bit 8 negative V/I limit.
// - Bit 9 external inhibit, bit 10 unregulated, bit 11 coupled protection.
// - Falling mask bit one: a 1-to-0 condition change sets the event bit.
// - Preset clears falling mask to zero.
module qstf_top (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [3:0] overvoltage_trip,
	input wire logic [3:0] overcurrent_trip,
	input wire logic [3:0] power_fail_shutdown,
	input wire logic [3:0] positive_power_limited,
	input wire logic [3:0] overtemperature_trip,
	input wire logic [3:0] negative_power_limited,
	input wire logic [3:0] negative_overvoltage_trip,
	input wire logic [3:0] positive_vi_limit,
	input wire logic [3:0] negative_vi_limit,
	input wire logic [3:0] external_inhibit,
	input wire logic [3:0] unregulated_output,
	input wire logic [3:0] coupled_protection_off,
	input wire logic [3:0] oscillation_trip,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic cmd_preset,
	input wire logic [1:0] cmd_sel,
	input wire logic [1:0] cmd_chan,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	output logic cmd_rvalid
);
	logic [15:0] raw_cond [0:3];
	logic [15:0] cond_s1_ff [0:3];
	logic [15:0] cond_s2_ff [0:3];
	logic [15:0] cond_s3_ff [0:3];
	logic [15:0] cond_stable_ff [0:3];
	logic [15:0] rising_mask_ff [0:3];
	logic [15:0] falling_mask_ff [0:3];
	logic [15:0] event_word [0:3];
	logic [15:0] cond_q [0:3];
	logic [3:0] event_clear;
	logic [15:0] rdata_ff;
	logic rvalid_ff;
	logic [15:0] nxt_rdata;
	logic [3:0] wr_rising;
	logic [3:0] wr_falling;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Register select compare, shared by the write and clear decode
	function automatic logic sel_is(input logic [1:0] sel, input logic [1:0] want);
		return sel == want;
	endfunction : sel_is

	// Bits 13 to 15 are never stored and never returned
	function automatic logic [15:0] keep_used(input logic [15:0] value);
		return value & qstf_pkg::USED_MASK;
	endfunction : keep_used

	// ------------------------------------------------------------
	// Condition word assembly
	// ------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			raw_cond[c] = 16'h0000;
			raw_cond[c][qstf_pkg::BIT_OVERVOLTAGE_TRIP] = overvoltage_trip[c];
			raw_cond[c][qstf_pkg::BIT_OVERCURRENT_TRIP] = overcurrent_trip[c];
			raw_cond[c][qstf_pkg::BIT_POWER_FAIL_SHUTDOWN] = power_fail_shutdown[c];
			raw_cond[c][qstf_pkg::BIT_POSITIVE_POWER_LIMITED] = positive_power_limited[c];
			raw_cond[c][qstf_pkg::BIT_OVERTEMPERATURE_TRIP] = overtemperature_trip[c];
			raw_cond[c][qstf_pkg::BIT_NEGATIVE_POWER_LIMITED] = negative_power_limited[c];
			raw_cond[c][qstf_pkg::BIT_NEGATIVE_OVERVOLTAGE_TRIP] = negative_overvoltage_trip[c];
			raw_cond[c][qstf_pkg::BIT_POSITIVE_VI_LIMIT] = positive_vi_limit[c];
			raw_cond[c][qstf_pkg::BIT_NEGATIVE_VI_LIMIT] = negative_vi_limit[c];
			raw_cond[c][qstf_pkg::BIT_EXTERNAL_INHIBIT] = external_inhibit[c];
			raw_cond[c][qstf_pkg::BIT_UNREGULATED_OUTPUT] = unregulated_output[c];
			raw_cond[c][qstf_pkg::BIT_COUPLED_PROTECTION_OFF] = coupled_protection_off[c];
			raw_cond[c][qstf_pkg::BIT_OSCILLATION_TRIP] = oscillation_trip[c];
		end
	end

	// ------------------------------------------------------------
	// Status pin synchronisers
	// ------------------------------------------------------------
	// Status pins are asynchronous; a bit moves only once stages two and three agree
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < 4; c++) begin
				cond_s1_ff[c] <= qstf_pkg::COND_RESET;
				cond_s2_ff[c] <= qstf_pkg::COND_RESET;
				cond_s3_ff[c] <= qstf_pkg::COND_RESET;
			end
		end else begin
			for (int c = 0; c < 4; c++) begin
				cond_s1_ff[c] <= raw_cond[c];
				cond_s2_ff[c] <= cond_s1_ff[c];
				cond_s3_ff[c] <= cond_s2_ff[c];
			end
		end
	end

	// A disagreeing pair holds the old value, so a one-cycle glitch never reaches the filter
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < 4; c++) begin
				cond_stable_ff[c] <= qstf_pkg::COND_RESET;
			end
		end else begin
			for (int c = 0; c < 4; c++) begin
				cond_stable_ff[c] <= (cond_s2_ff[c] & cond_s3_ff[c])
					| (cond_stable_ff[c] & (cond_s2_ff[c] | cond_s3_ff[c]));
			end
		end
	end

	// ------------------------------------------------------------
	// Mask registers
	// ------------------------------------------------------------
	// Preset outranks a write issued in the same cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < 4; c++) begin
				rising_mask_ff[c] <= qstf_pkg::RISING_MASK_PRESET;
			end
		end else if (cmd_preset) begin
			for (int c = 0; c < 4; c++) begin
				rising_mask_ff[c] <= qstf_pkg::RISING_MASK_PRESET;
			end
		end else begin
			for (int c = 0; c < 4; c++) begin
				if (wr_rising[c]) begin
					rising_mask_ff[c] <= keep_used(cmd_wdata);
				end
			end
		end
	end

	// Unused positions are dropped on write so they can never read back
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < 4; c++) begin
				falling_mask_ff[c] <= qstf_pkg::FALLING_MASK_PRESET;
			end
		end else if (cmd_preset) begin
			for (int c = 0; c < 4; c++) begin
				falling_mask_ff[c] <= qstf_pkg::FALLING_MASK_PRESET;
			end
		end else begin
			for (int c = 0; c < 4; c++) begin
				if (wr_falling[c]) begin
					falling_mask_ff[c] <= keep_used(cmd_wdata);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Per-channel filters
	// ------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			wr_rising[c] = cmd_wr && sel_is(cmd_sel, qstf_pkg::SEL_RISING_MASK) && (cmd_chan == c[1:0]);
			wr_falling[c] = cmd_wr && sel_is(cmd_sel, qstf_pkg::SEL_FALLING_MASK) && (cmd_chan == c[1:0]);
			// Writes to the event and condition selects decode to nothing and are ignored
			event_clear[c] = cmd_rd && sel_is(cmd_sel, qstf_pkg::SEL_EVENT) && (cmd_chan == c[1:0]);
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_chan
		qstf_chan u_chan (
			.mclk(mclk),
			.rst_b(rst_b),
			.cond_word(cond_stable_ff[g]),
			.rising_mask(rising_mask_ff[g]),
			.falling_mask(falling_mask_ff[g]),
			.event_clear(event_clear[g]),
			.event_word(event_word[g]),
			.cond_q(cond_q[g])
		);
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		case (cmd_sel)
			qstf_pkg::SEL_RISING_MASK: nxt_rdata = keep_used(rising_mask_ff[cmd_chan]);
			qstf_pkg::SEL_FALLING_MASK: nxt_rdata = keep_used(falling_mask_ff[cmd_chan]);
			qstf_pkg::SEL_EVENT: nxt_rdata = event_word[cmd_chan];
			qstf_pkg::SEL_CONDITION: nxt_rdata = cond_q[cmd_chan];
			default: nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= cmd_rd;
		end
	end

	// Read data holds between reads so a slow host may take it late
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else if (cmd_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign cmd_rdata = rdata_ff;
	assign cmd_rvalid = rvalid_ff;
endmodule : qstf_top

// [qstf_pkg.sv]
package qstf_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int unsigned NUM_CHAN = 4;
	localparam int unsigned CHAN_W = 2;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned USED_BITS = 13;

	// ------------------------------------------------------------
	// Condition bit positions
	// ------------------------------------------------------------
	localparam int unsigned BIT_OVERVOLTAGE_TRIP = 0;
	localparam int unsigned BIT_OVERCURRENT_TRIP = 1;
	localparam int unsigned BIT_POWER_FAIL_SHUTDOWN = 2;
	localparam int unsigned BIT_POSITIVE_POWER_LIMITED = 3;
	localparam int unsigned BIT_OVERTEMPERATURE_TRIP = 4;
	localparam int unsigned BIT_NEGATIVE_POWER_LIMITED = 5;
	localparam int unsigned BIT_NEGATIVE_OVERVOLTAGE_TRIP = 6;
	localparam int unsigned BIT_POSITIVE_VI_LIMIT = 7;
	localparam int unsigned BIT_NEGATIVE_VI_LIMIT = 8;
	localparam int unsigned BIT_EXTERNAL_INHIBIT = 9;
	localparam int unsigned BIT_UNREGULATED_OUTPUT = 10;
	localparam int unsigned BIT_COUPLED_PROTECTION_OFF = 11;
	localparam int unsigned BIT_OSCILLATION_TRIP = 12;

	// ------------------------------------------------------------
	// Reset and preset values
	// ------------------------------------------------------------
	localparam logic [15:0] USED_MASK = 16'h1fff;
	localparam logic [15:0] RISING_MASK_PRESET = 16'h1fff;
	localparam logic [15:0] FALLING_MASK_PRESET = 16'h0000;
	localparam logic [15:0] COND_RESET = 16'h0000;
	localparam logic [15:0] EVENT_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Command port register selects
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_RISING_MASK = 2'h0;
	localparam logic [1:0] SEL_FALLING_MASK = 2'h1;
	localparam logic [1:0] SEL_EVENT = 2'h2;
	localparam logic [1:0] SEL_CONDITION = 2'h3;
endpackage : qstf_pkg

// [qstf_chan.sv]
module qstf_chan (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [15:0] cond_word,
	input wire logic [15:0] rising_mask,
	input wire logic [15:0] falling_mask,
	input wire logic event_clear,
	output logic [15:0] event_word,
	output logic [15:0] cond_q
);
	logic [15:0] cond_prev_ff;
	logic [15:0] event_ff;
	logic [15:0] nxt_event;
	logic [15:0] hits;

	// ------------------------------------------------------------
	// Transition filter
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cond_prev_ff <= qstf_pkg::COND_RESET;
		end else begin
			cond_prev_ff <= cond_word;
		end
	end

	always_comb begin
		hits = ((~cond_prev_ff & cond_word & rising_mask)
			| (cond_prev_ff & ~cond_word & falling_mask))
			& qstf_pkg::USED_MASK;
		// New hits win over a clear in the same cycle
		nxt_event = (event_clear ? qstf_pkg::EVENT_RESET : event_ff) | hits;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			event_ff <= qstf_pkg::EVENT_RESET;
		end else begin
			event_ff <= nxt_event;
		end
	end

	assign event_word = event_ff;
	assign cond_q = cond_prev_ff;
endmodule : qstf_chan

// [qstf_checker.sv]
module qstf_checker (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic cmd_preset,
	input wire logic [1:0] cmd_sel,
	input wire logic [1:0] cmd_chan,
	input wire logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_rvalid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_read_answered: assert property (cmd_rd |=> cmd_rvalid) else $error("read not answered");
	a_answer_cause: assert property (cmd_rvalid |-> $past(cmd_rd)) else $error("stray answer");
	a_unused_zero: assert property (cmd_rvalid |-> cmd_rdata[15:13] == 3'h0) else $error("unused bits set");
	a_rdata_holds: assert property (!cmd_rvalid |-> $stable(cmd_rdata)) else $error("read data moved");
	a_preset_rising: assert property (cmd_preset ##1 (cmd_rd && cmd_sel == 2'h0) |=> cmd_rdata == 16'h1fff)
		else $error("rising preset wrong");
	a_preset_falling: assert property (cmd_preset ##1 (cmd_rd && cmd_sel == 2'h1) |=> cmd_rdata == 16'h0)
		else $error("falling preset wrong");
	a_rising_readback: assert property ((cmd_wr && !cmd_preset && cmd_sel == 2'h0) ##1
		(cmd_rd && cmd_sel == 2'h0 && cmd_chan == $past(cmd_chan) && !cmd_wr && !cmd_preset)
		|=> cmd_rdata == ($past(cmd_wdata, 2) & 16'h1fff)) else $error("rising readback wrong");
	a_falling_readback: assert property ((cmd_wr && !cmd_preset && cmd_sel == 2'h1) ##1
		(cmd_rd && cmd_sel == 2'h1 && cmd_chan == $past(cmd_chan) && !cmd_wr && !cmd_preset)
		|=> cmd_rdata == ($past(cmd_wdata, 2) & 16'h1fff)) else $error("falling readback wrong");
endmodule : qstf_checker

bind qstf_top qstf_checker i_chk (.mclk(mclk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
	.cmd_preset(cmd_preset), .cmd_sel(cmd_sel), .cmd_chan(cmd_chan), .cmd_wdata(cmd_wdata),
	.cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));

// [tb_questionable_status_transition_filter.sv]
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("unexpected %0t read got %h want %h", $time, a, b); end end
module tb_questionable_status_transition_filter;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0, rst_b = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0, cmd_preset = 1'b0, cmd_rvalid;
	logic [1:0] cmd_sel = 2'h0, cmd_chan = 2'h0;
	logic [15:0] cmd_wdata = 16'h0, cmd_rdata;
	logic [12:0][3:0] pin = '0;
	int err_count = 0, n_tests = 0;
	always #5 mclk = ~mclk;
	qstf_top i_dut (.mclk(mclk), .rst_b(rst_b), .overvoltage_trip(pin[0]), .overcurrent_trip(pin[1]),
		.power_fail_shutdown(pin[2]), .positive_power_limited(pin[3]), .overtemperature_trip(pin[4]),
		.negative_power_limited(pin[5]), .negative_overvoltage_trip(pin[6]), .positive_vi_limit(pin[7]),
		.negative_vi_limit(pin[8]), .external_inhibit(pin[9]), .unregulated_output(pin[10]),
		.coupled_protection_off(pin[11]), .oscillation_trip(pin[12]), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_preset(cmd_preset), .cmd_sel(cmd_sel), .cmd_chan(cmd_chan), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Strobes stay up; the next command drops them, so no signal is assigned twice per edge
	task automatic cmd(input logic w, input logic p, input logic [1:0] s, input logic [1:0] c, input logic [15:0] v);
		cmd_wr <= w;
		cmd_rd <= 1'b0;
		cmd_preset <= p;
		cmd_sel <= s;
		cmd_chan <= c;
		cmd_wdata <= v;
		@(posedge mclk);
	endtask : cmd
	task automatic rchk(input logic [1:0] s, input logic [1:0] c, input logic [15:0] e);
		cmd_wr <= 1'b0;
		cmd_preset <= 1'b0;
		cmd_rd <= 1'b1;
		cmd_sel <= s;
		cmd_chan <= c;
		@(posedge mclk);
		cmd_rd <= 1'b0;
		#1;
		`CHK({cmd_rvalid, cmd_rdata}, {1'b1, e})
		@(posedge mclk);
	endtask : rchk
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_state();
		for (int c = 0; c < 4; c++) begin
			rchk(2'h0, 2'(c), 16'h1fff);
			rchk(2'h1, 2'(c), 16'h0);
		end
	endtask : t_reset_state
	task automatic t_mask_rw();
		for (int c = 0; c < 4; c++) begin
			cmd(1'b1, 1'b0, 2'h0, 2'(c), 16'hfff0 | 16'(c));
			rchk(2'h0, 2'(c), 16'h1ff0 | 16'(c));
			cmd(1'b1, 1'b0, 2'h1, 2'(c), 16'he000 | 16'(c << 4));
			rchk(2'h1, 2'(c), 16'(c << 4));
		end
		for (int c = 0; c < 4; c++) begin
			rchk(2'h0, 2'(c), 16'h1ff0 | 16'(c));
		end
		// Writes to the event and condition selects must leave both untouched
		cmd(1'b1, 1'b0, 2'h2, 2'h0, 16'hffff);
		rchk(2'h2, 2'h0, 16'h0);
		cmd(1'b1, 1'b0, 2'h3, 2'h0, 16'hffff);
		rchk(2'h3, 2'h0, 16'h0);
	endtask : t_mask_rw
	task automatic t_preset();
		// Preset must beat the write issued with it, for either mask
		cmd(1'b1, 1'b1, 2'h1, 2'h2, 16'hffff);
		rchk(2'h1, 2'h2, 16'h0);
		cmd(1'b1, 1'b1, 2'h0, 2'h3, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			rchk(2'h0, 2'(c), 16'h1fff);
			rchk(2'h1, 2'(c), 16'h0);
		end
	endtask : t_preset
	task automatic t_edges();
		logic [1:0] c;
		logic [15:0] bit_v;
		for (int b = 0; b < 13; b++) begin
			for (int m = 0; m < 4; m++) begin
				c = 2'(b % 4);
				bit_v = 16'h1 << b;
				cmd(1'b1, 1'b0, 2'h0, c, m[0] ? bit_v : 16'h0);
				cmd(1'b1, 1'b0, 2'h1, c, m[1] ? bit_v : 16'h0);
				rchk(2'h2, c, 16'h0);
				pin[b][c] <= 1'b1;
				repeat (10) @(posedge mclk);
				rchk(2'h3, c, bit_v);
				rchk(2'h2, c, m[0] ? bit_v : 16'h0);
				rchk(2'h2, c, 16'h0);
				rchk(2'h2, c + 2'h1, 16'h0);
				pin[b][c] <= 1'b0;
				repeat (10) @(posedge mclk);
				rchk(2'h2, c, m[1] ? bit_v : 16'h0);
			end
		end
	endtask : t_edges
	task automatic report_and_stop();
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_reset_state();
		t_mask_rw();
		t_preset();
		t_edges();
		report_and_stop();
	end
	initial begin
		#60000;
		err_count++;
		report_and_stop();
	end
endmodule : tb_questionable_status_transition_filter
